// file: inc/sfrb_pkg.sv
// shared constants and types for the serial flash read/buffer/program block
package sfrb_pkg;

	// command opcodes
	localparam logic [7:0] OP_CONT_READ     = 8'h03;
	localparam logic [7:0] OP_PAGE_READ     = 8'hD2;
	localparam logic [7:0] OP_BUF1_READ_HI  = 8'hD4;
	localparam logic [7:0] OP_BUF1_READ_LO  = 8'hD1;
	localparam logic [7:0] OP_BUF2_READ_HI  = 8'hD6;
	localparam logic [7:0] OP_BUF2_READ_LO  = 8'hD3;
	localparam logic [7:0] OP_BUF1_WRITE    = 8'h84;
	localparam logic [7:0] OP_BUF2_WRITE    = 8'h87;
	localparam logic [7:0] OP_BUF1_PROG     = 8'h83;
	localparam logic [7:0] OP_BUF2_PROG     = 8'h86;

	// array geometry and command framing
	localparam int PAGE_COUNT       = 2048;
	localparam int PAGE_BYTES_STD   = 264;
	localparam int PAGE_BYTES_BIN   = 256;
	localparam int ADDR_BYTES       = 3;
	localparam int PAGE_READ_DUMMY  = 4;
	localparam int BUF_READ_DUMMY   = 1;
	localparam int WR_FIFO_DEPTH    = 16;
	localparam logic [7:0] ERASED_BYTE = 8'hFF;

	// self-timed erase plus program time, longest time rounds down
	localparam int CLK_MHZ             = 200;
	localparam int ERASE_PROG_TIME_US  = 20;
	localparam int ERASE_PROG_CYCLES   = ERASE_PROG_TIME_US * CLK_MHZ;

	// reset values
	localparam logic PIN_CS_RESET  = 1'b1;
	localparam logic [2:0] BIT_CNT_RESET = 3'h0;
	localparam logic [8:0] IDX_RESET     = 9'h000;

	// one buffer write travelling through the write fifo
	typedef struct packed {
		logic       buf_sel;
		logic [8:0] offset;
		logic [7:0] data;
	} sfrb_wr_word_type;

	typedef enum logic [2:0] {
		CMD_IDLE,
		CMD_OPCODE,
		CMD_ADDR,
		CMD_DUMMY,
		CMD_READ,
		CMD_WRITE,
		CMD_PROG,
		CMD_IGNORE
	} sfrb_cmd_state_type;

	typedef enum logic [1:0] {
		RD_ARRAY,
		RD_PAGE,
		RD_BUFFER
	} sfrb_read_kind_type;

	typedef enum logic [2:0] {
		PG_IDLE,
		PG_FLUSH,
		PG_ERASE,
		PG_WRITE,
		PG_WAIT
	} sfrb_prog_state_type;

endpackage : sfrb_pkg

// file: design/sfrb_sequencer.sv
// serial flash command sequencer with two page buffers and a write fifo
//
// Functional notes
// - opcode 03H plus three address bytes, then data streams out
// - 264-byte mode: 20-bit address, 11 page bits, nine byte bits
// - 256-byte mode: 19-bit address, 11 page bits, 8 byte bits
// - continuous read crosses page ends into next page without gaps
// - continuous read wraps from array end to first page without gaps
// - chip select rising ends any read, output goes high impedance
// - array and page reads leave both buffers untouched
// - opcode D2H, three address bytes, four dummy bytes, then page data
// - page read wraps to the start of the same page
// - D4H or D1H reads buffer 1, D6H or D3H reads buffer 2
// - buffer address: low nine bits, or low eight bits in 256 mode
// - buffer read needs exactly one dummy byte before data
// - buffer read wraps to buffer start after its last byte
// - 84H writes buffer 1, 87H buffer 2, from the given offset
// - write data fills successive locations, wrapping at buffer end
// - buffer write continues until chip select rises
// - 83H programs buffer 1, 86H buffer 2 into a page
// - program address: page bits at 19:9, or 18:8 in 256 mode
// - on chip select rising: erase page to ones, then copy buffer
// - busy is reported for the whole erase and program
// - command starts on chip select falling with an 8-bit opcode
// - all bytes move most significant bit first
`timescale 1ns/100ps

// simple synchronous fifo with valid/ready on both sides
module sfrb_fifo
	import sfrb_pkg::*;
#(
	parameter int WIDTH = 18,
	parameter int DEPTH = WR_FIFO_DEPTH
)
(
	input  wire logic             clk,
	input  wire logic             rst,
	input  wire logic             in_valid,
	output logic                  in_ready,
	input  wire logic [WIDTH-1:0] in_data,
	output logic                  out_valid,
	input  wire logic             out_ready,
	output logic [WIDTH-1:0]      out_data
);
	localparam int AW = $clog2(DEPTH);

	logic [WIDTH-1:0] mem [DEPTH];
	logic [AW:0]      wr_ptr;
	logic [AW:0]      rd_ptr;
	logic             full;
	logic             empty;

	// pointer compare with wrap bit
	assign empty     = (wr_ptr == rd_ptr);
	assign full      = (wr_ptr[AW-1:0] == rd_ptr[AW-1:0]) &&
	                   (wr_ptr[AW] != rd_ptr[AW]);
	assign in_ready  = !full;
	assign out_valid = !empty;
	assign out_data  = mem[rd_ptr[AW-1:0]];

	// storage write
	always_ff @(posedge clk)
	begin
		if (in_valid && !full)
			mem[wr_ptr[AW-1:0]] <= in_data;
	end

	// pointers
	always_ff @(posedge clk or posedge rst)
	begin
		if (rst)
		begin
			wr_ptr <= '0;
			rd_ptr <= '0;
		end
		else
		begin
			if (in_valid && !full)
				wr_ptr <= wr_ptr + 1'b1;
			if (out_ready && !empty)
				rd_ptr <= rd_ptr + 1'b1;
		end
	end

endmodule : sfrb_fifo

// device side of the serial flash: command decode, array, buffers
module sfrb_sequencer
	import sfrb_pkg::*;
#(
	parameter int PAGES      = PAGE_COUNT,
	parameter int EP_CYCLES  = ERASE_PROG_CYCLES,
	parameter int FIFO_DEPTH = WR_FIFO_DEPTH
)
(
	input  wire logic clk,
	input  wire logic rst,
	input  wire logic cs_n,
	input  wire logic sck,
	input  wire logic si,
	input  wire logic page_256,
	output logic      so,
	output logic      so_oe,
	output logic      busy,
	output logic      wr_fifo_ready
);
	localparam int ARRAY_BYTES = PAGES * PAGE_BYTES_STD;
	localparam int AAW         = $clog2(ARRAY_BYTES);
	localparam int WW          = $bits(sfrb_wr_word_type);

	// storage
	logic [7:0]          array_mem [ARRAY_BYTES];
	logic [7:0]          buf_mem   [2][PAGE_BYTES_STD];

	// pin synchronisers
	logic                cs_s1, cs_s2, cs_prev;
	logic                sck_s1, sck_s2, sck_prev;
	logic                si_s1, si_s2;
	logic                pb_s1, pb_s2;
	logic                cs_fall, cs_rise, sck_rise, sck_fall;

	// command framing
	sfrb_cmd_state_type  state;
	logic [7:0]          opcode;
	logic [23:0]         addr;
	logic [2:0]          byte_cnt;
	logic [2:0]          bit_cnt;
	logic [7:0]          in_shift;
	logic [7:0]          rx_byte;
	logic                byte_done;
	logic                addr_last;
	logic [23:0]         full_addr;
	logic                op_cont, op_page, op_bread, op_write, op_prog;
	logic                op_buf2;
	logic [2:0]          dummy_need;
	logic                enter_read;
	logic                enter_write;

	// read pointer and output shifter
	sfrb_read_kind_type  rd_kind;
	logic                rd_sel;
	logic [10:0]         rd_page;
	logic [8:0]          rd_byte;
	logic [8:0]          last_byte;
	logic [10:0]         dec_page;
	logic [8:0]          dec_byte;
	logic [8:0]          dec_buf;
	logic [7:0]          fetch;
	logic [2:0]          out_cnt;
	logic [7:0]          out_shift;
	logic                advance;

	// write path
	logic                wr_sel;
	logic [8:0]          wr_ptr;
	sfrb_wr_word_type    push_word;
	sfrb_wr_word_type    pop_word;
	logic                push;
	logic                pop_valid;
	logic                pop_ready;

	// program engine
	sfrb_prog_state_type pg_state;
	logic                pg_sel;
	logic [10:0]         pg_page;
	logic [8:0]          pg_idx;
	logic [31:0]         pg_timer;
	logic                prog_req;

	function automatic logic [AAW-1:0] arr_index(input logic [10:0] pg,
	                                             input logic [8:0]  bt);
		arr_index = AAW'(32'(pg) * 32'(PAGE_BYTES_STD) + 32'(bt));
	endfunction : arr_index

	// two flip-flops on every pin
	always_ff @(posedge clk or posedge rst)
	begin
		if (rst)
		begin
			cs_s1    <= PIN_CS_RESET;
			cs_s2    <= PIN_CS_RESET;
			cs_prev  <= PIN_CS_RESET;
			sck_s1   <= 1'b0;
			sck_s2   <= 1'b0;
			sck_prev <= 1'b0;
			si_s1    <= 1'b0;
			si_s2    <= 1'b0;
			pb_s1    <= 1'b0;
			pb_s2    <= 1'b0;
		end
		else
		begin
			cs_s1    <= cs_n;
			cs_s2    <= cs_s1;
			cs_prev  <= cs_s2;
			sck_s1   <= sck;
			sck_s2   <= sck_s1;
			sck_prev <= sck_s2;
			si_s1    <= si;
			si_s2    <= si_s1;
			pb_s1    <= page_256;
			pb_s2    <= pb_s1;
		end
	end

	// edge detection on synchronised pins
	assign cs_fall  = cs_prev && !cs_s2;
	assign cs_rise  = !cs_prev && cs_s2;
	assign sck_rise = !cs_s2 && sck_s2 && !sck_prev;
	assign sck_fall = !cs_s2 && !sck_s2 && sck_prev;

	// bit counter and input shifter, msb first
	assign rx_byte   = {in_shift[6:0], si_s2};
	assign byte_done = sck_rise && (bit_cnt == 3'h7);

	always_ff @(posedge clk or posedge rst)
	begin
		if (rst)
		begin
			bit_cnt  <= BIT_CNT_RESET;
			in_shift <= 8'h00;
		end
		else if (cs_fall)
			bit_cnt <= BIT_CNT_RESET;
		else if (sck_rise)
		begin
			bit_cnt  <= bit_cnt + 3'h1;
			in_shift <= rx_byte;
		end
	end

	// opcode decode
	assign op_cont  = (opcode == OP_CONT_READ);
	assign op_page  = (opcode == OP_PAGE_READ);
	assign op_bread = (opcode == OP_BUF1_READ_HI) ||
	                  (opcode == OP_BUF1_READ_LO) ||
	                  (opcode == OP_BUF2_READ_HI) ||
	                  (opcode == OP_BUF2_READ_LO);
	assign op_write = (opcode == OP_BUF1_WRITE) ||
	                  (opcode == OP_BUF2_WRITE);
	assign op_prog  = (opcode == OP_BUF1_PROG) ||
	                  (opcode == OP_BUF2_PROG);
	assign op_buf2  = (opcode == OP_BUF2_READ_HI) ||
	                  (opcode == OP_BUF2_READ_LO) ||
	                  (opcode == OP_BUF2_WRITE) ||
	                  (opcode == OP_BUF2_PROG);
	assign dummy_need = op_page ? 3'(PAGE_READ_DUMMY)
	                            : 3'(BUF_READ_DUMMY);
	assign addr_last  = (byte_cnt == 3'(ADDR_BYTES - 1));
	assign full_addr  = (state == CMD_ADDR) ? {addr[15:0], rx_byte} : addr;
	assign enter_read = byte_done &&
	                    ((state == CMD_ADDR && addr_last && op_cont) ||
	                     (state == CMD_DUMMY &&
	                      byte_cnt == dummy_need - 3'h1));
	assign enter_write = byte_done && state == CMD_ADDR && addr_last &&
	                     op_write;

	// command phase sequencing
	always_ff @(posedge clk or posedge rst)
	begin
		if (rst)
		begin
			state    <= CMD_IDLE;
			opcode   <= 8'h00;
			addr     <= 24'h000000;
			byte_cnt <= 3'h0;
		end
		else if (cs_rise)
			state <= CMD_IDLE;
		else if (cs_fall)
		begin
			state    <= CMD_OPCODE;
			byte_cnt <= 3'h0;
		end
		else if (byte_done)
		begin
			case (state)
				CMD_OPCODE:
				begin
					opcode   <= rx_byte;
					byte_cnt <= 3'h0;
					if (rx_byte == OP_CONT_READ || rx_byte == OP_PAGE_READ ||
					    rx_byte == OP_BUF1_READ_HI ||
					    rx_byte == OP_BUF1_READ_LO ||
					    rx_byte == OP_BUF2_READ_HI ||
					    rx_byte == OP_BUF2_READ_LO ||
					    rx_byte == OP_BUF1_WRITE || rx_byte == OP_BUF2_WRITE ||
					    rx_byte == OP_BUF1_PROG || rx_byte == OP_BUF2_PROG)
						state <= CMD_ADDR;
					else
						state <= CMD_IGNORE;
				end
				CMD_ADDR:
				begin
					addr     <= full_addr;
					byte_cnt <= addr_last ? 3'h0 : byte_cnt + 3'h1;
					if (addr_last)
					begin
						if (op_cont)
							state <= CMD_READ;
						else if (op_page || op_bread)
							state <= CMD_DUMMY;
						else if (op_write)
							state <= CMD_WRITE;
						else
							state <= CMD_PROG;
					end
				end
				CMD_DUMMY:
				begin
					byte_cnt <= byte_cnt + 3'h1;
					if (byte_cnt == dummy_need - 3'h1)
						state <= CMD_READ;
				end
				default:
					state <= state;
			endcase
		end
	end

	// address decode per page size mode
	assign last_byte = pb_s2 ? 9'(PAGE_BYTES_BIN - 1)
	                         : 9'(PAGE_BYTES_STD - 1);
	assign dec_page  = pb_s2 ? full_addr[18:8] : full_addr[19:9];
	assign dec_byte  = pb_s2 ? {1'b0, full_addr[7:0]}
	                         : full_addr[8:0];
	assign dec_buf   = pb_s2 ? {1'b0, full_addr[7:0]}
	                         : full_addr[8:0];

	// read source: array and page reads bypass the buffers
	assign fetch = (rd_kind == RD_BUFFER) ? buf_mem[rd_sel][rd_byte]
	                                      : array_mem[arr_index(rd_page,
	                                                            rd_byte)];
	assign advance = sck_fall && state == CMD_READ && out_cnt == 3'h0;

	// read pointer load and advance
	always_ff @(posedge clk or posedge rst)
	begin
		if (rst)
		begin
			rd_kind <= RD_ARRAY;
			rd_sel  <= 1'b0;
			rd_page <= 11'h000;
			rd_byte <= IDX_RESET;
		end
		else if (enter_read)
		begin
			rd_kind <= op_cont ? RD_ARRAY : (op_page ? RD_PAGE : RD_BUFFER);
			rd_sel  <= op_buf2;
			rd_page <= dec_page;
			rd_byte <= op_bread ? dec_buf : dec_byte;
		end
		else if (advance)
		begin
			if (rd_byte != last_byte)
				rd_byte <= rd_byte + 9'h001;
			else
			begin
				rd_byte <= IDX_RESET;
				if (rd_kind == RD_ARRAY)
					rd_page <= (32'(rd_page) == PAGES - 1) ? 11'h000
					                                       : rd_page + 11'h001;
			end
		end
	end

	// serial output, new bit on each falling clock edge
	always_ff @(posedge clk or posedge rst)
	begin
		if (rst)
		begin
			so        <= 1'b0;
			so_oe     <= 1'b0;
			out_cnt   <= 3'h0;
			out_shift <= 8'h00;
		end
		else if (cs_rise || cs_fall)
		begin
			so_oe   <= 1'b0;
			out_cnt <= 3'h0;
		end
		else if (enter_read)
			out_cnt <= 3'h0;
		else if (sck_fall && state == CMD_READ)
		begin
			so_oe   <= 1'b1;
			out_cnt <= out_cnt + 3'h1;
			if (out_cnt == 3'h0)
			begin
				so        <= fetch[7];
				out_shift <= {fetch[6:0], 1'b0};
			end
			else
			begin
				so        <= out_shift[7];
				out_shift <= {out_shift[6:0], 1'b0};
			end
		end
	end

	// buffer write pointer, wraps at buffer end
	assign push      = byte_done && state == CMD_WRITE;
	assign push_word = '{buf_sel: wr_sel, offset: wr_ptr, data: rx_byte};

	always_ff @(posedge clk or posedge rst)
	begin
		if (rst)
		begin
			wr_sel <= 1'b0;
			wr_ptr <= IDX_RESET;
		end
		else if (enter_write)
		begin
			wr_sel <= op_buf2;
			wr_ptr <= dec_buf;
		end
		else if (push)
			wr_ptr <= (wr_ptr == last_byte) ? IDX_RESET
			                                : wr_ptr + 9'h001;
	end

	// write fifo between the serial side and the buffers
	sfrb_fifo #(
		.WIDTH (WW),
		.DEPTH (FIFO_DEPTH)
	) u_wr_fifo (
		.clk       (clk),
		.rst       (rst),
		.in_valid  (push),
		.in_ready  (wr_fifo_ready),
		.in_data   (push_word),
		.out_valid (pop_valid),
		.out_ready (pop_ready),
		.out_data  (pop_word)
	);

	// buffers are not refilled while the engine copies one out,
	// but queued bytes still drain before the erase starts
	assign pop_ready = (pg_state == PG_IDLE) || (pg_state == PG_FLUSH);

	// buffer storage, fed only from the fifo
	always_ff @(posedge clk)
	begin
		if (pop_valid && pop_ready)
			buf_mem[pop_word.buf_sel][pop_word.offset] <= pop_word.data;
	end

	// program request on deselect after a complete program header
	assign prog_req = cs_rise && state == CMD_PROG && !busy;

	// erase then program engine, self timed
	always_ff @(posedge clk or posedge rst)
	begin
		if (rst)
		begin
			pg_state <= PG_IDLE;
			pg_sel   <= 1'b0;
			pg_page  <= 11'h000;
			pg_idx   <= IDX_RESET;
			pg_timer <= 32'h00000000;
			busy     <= 1'b0;
		end
		else
		begin
			case (pg_state)
				PG_IDLE:
					if (prog_req)
					begin
						pg_state <= PG_FLUSH;
						pg_sel   <= op_buf2;
						pg_page  <= pb_s2 ? addr[18:8] : addr[19:9];
						pg_idx   <= IDX_RESET;
						pg_timer <= 32'h00000000;
						busy     <= 1'b1;
					end
				PG_FLUSH:
				begin
					pg_timer <= pg_timer + 32'h1;
					if (!pop_valid)
						pg_state <= PG_ERASE;
				end
				PG_ERASE:
				begin
					pg_timer <= pg_timer + 32'h1;
					pg_idx   <= (pg_idx == last_byte) ? IDX_RESET : pg_idx + 9'h001;
					if (pg_idx == last_byte)
						pg_state <= PG_WRITE;
				end
				PG_WRITE:
				begin
					pg_timer <= pg_timer + 32'h1;
					pg_idx   <= pg_idx + 9'h001;
					if (pg_idx == last_byte)
						pg_state <= PG_WAIT;
				end
				PG_WAIT:
				begin
					pg_timer <= pg_timer + 32'h1;
					if (pg_timer >= 32'(EP_CYCLES - 1))
					begin
						pg_state <= PG_IDLE;
						busy     <= 1'b0;
					end
				end
				default:
					pg_state <= PG_IDLE;
			endcase
		end
	end

	// array storage, written only by the engine
	always_ff @(posedge clk)
	begin
		if (pg_state == PG_ERASE)
			array_mem[arr_index(pg_page, pg_idx)] <= ERASED_BYTE;
		else if (pg_state == PG_WRITE)
			array_mem[arr_index(pg_page, pg_idx)] <=
				buf_mem[pg_sel][pg_idx];
	end

endmodule : sfrb_sequencer

// file: sim/sfrb_sequencer_assertions.sv
// concurrent checks on the sequencer pins
`timescale 1ns/100ps
module sfrb_sequencer_assertions
	import sfrb_pkg::*;
#(
	parameter int PAGES      = PAGE_COUNT,
	parameter int EP_CYCLES  = ERASE_PROG_CYCLES,
	parameter int FIFO_DEPTH = WR_FIFO_DEPTH
)
(
	input wire logic clk,
	input wire logic rst,
	input wire logic cs_n,
	input wire logic sck,
	input wire logic si,
	input wire logic page_256,
	input wire logic so,
	input wire logic so_oe,
	input wire logic busy,
	input wire logic wr_fifo_ready
);
	int busy_len;

	// length of the current busy stretch
	always_ff @(posedge clk or posedge rst)
		if (rst)
			busy_len <= 0;
		else if (busy)
			busy_len <= busy_len + 1;
		else
			busy_len <= 0;

	default clocking dflt @(posedge clk); endclocking
	default disable iff (rst);

	// chip select held high long enough for the output to let go
	sequence s_deselect;
		cs_n [*6];
	endsequence
	// program request seen after chip select rose
	sequence s_request;
		$past(cs_n, 2) ##0 cs_n;
	endsequence

	reset_quiet_a: assert property (
		$fell(rst) |-> !so_oe && !busy && wr_fifo_ready)
		else $error("outputs not idle after reset");
	deselect_hiz_a: assert property (
		s_deselect |-> !so_oe)
		else $error("output driven while deselected");
	header_quiet_a: assert property (
		$fell(cs_n) |-> !so_oe [*8])
		else $error("output driven during command header");
	oe_start_a: assert property (
		$rose(so_oe) |-> !cs_n && !sck)
		else $error("output enabled outside a data bit");
	read_hold_a: assert property (
		$fell(so_oe) |-> $past(cs_n, 3) && cs_n)
		else $error("read stopped while still selected");
	so_steady_a: assert property (
		so_oe && sck && $past(sck) |-> $stable(so))
		else $error("output bit moved while clock high");
	busy_start_a: assert property (
		$rose(busy) |-> s_request)
		else $error("busy without chip select rise");
	busy_length_a: assert property (
		$fell(busy) |-> busy_len >= EP_CYCLES - 2 && busy_len <= EP_CYCLES)
		else $error("busy length wrong");
endmodule : sfrb_sequencer_assertions

bind sfrb_sequencer sfrb_sequencer_assertions #(
	.PAGES(PAGES),
	.EP_CYCLES(EP_CYCLES),
	.FIFO_DEPTH(FIFO_DEPTH)
) i_sfrb_chk (
	.clk(clk),
	.rst(rst),
	.cs_n(cs_n),
	.sck(sck),
	.si(si),
	.page_256(page_256),
	.so(so),
	.so_oe(so_oe),
	.busy(busy),
	.wr_fifo_ready(wr_fifo_ready)
);

// file: sim/sfrb_host_model.sv
// host serial controller model, mode 0, bytes msb first
`timescale 1ns/100ps
module sfrb_host_model
(
	input wire logic clk,
	input wire logic so,
	input wire logic so_oe,
	output logic     cs_n,
	output logic     sck,
	output logic     si
);
	logic idle;
	wire  so_line;

	// released data line shows the inverse of its last level
	assign so_line = so_oe ? so : ~so;

	initial
	begin
		cs_n = 1'b1;
		sck  = 1'b0;
		si   = 1'b0;
		idle = 1'b1;
	end

	// data in toggles every cycle while no device is selected
	always @(posedge clk)
		if (idle)
			si <= ~si;

	// select falls first, header bits follow
	task automatic start_cmd();
		idle = 1'b0;
		@(posedge clk) cs_n <= 1'b0;
		repeat (4) @(posedge clk);
	endtask : start_cmd

	// one byte each way, low 6 clk and high 4 clk per bit
	task automatic xfer(input logic [7:0] tx, output logic [7:0] rx);
		for (int b = 7; b >= 0; b--)
		begin
			@(posedge clk) si <= tx[b];
			repeat (4) @(posedge clk);
			@(posedge clk)
			begin
				rx[b] = so_line;
				sck <= 1'b1;
			end
			repeat (3) @(posedge clk);
			@(posedge clk) sck <= 1'b0;
		end
	endtask : xfer

	// select held low to here, then released
	task automatic stop_cmd();
		@(posedge clk) cs_n <= 1'b1;
		repeat (5) @(posedge clk);
		idle = 1'b1;
	endtask : stop_cmd
endmodule : sfrb_host_model

// file: sim/sfrb_sequencer_test.sv
// self-checking bench for the serial flash sequencer
`timescale 1ns/100ps
module sfrb_sequencer_test
	import sfrb_pkg::*;
();
	localparam int EP = 2000;
	localparam int PG = 8;

	typedef struct packed {
		logic [7:0] wop;
		logic [7:0] rop;
		logic       mode;
		logic [8:0] woff;
		logic [8:0] roff;
		logic [7:0] base;
		logic [7:0] exp0;
	} sfrb_row_type;

	// write four bytes, read two back
	localparam sfrb_row_type rows [4] = '{
		'{8'h84, 8'hD4, 1'b0, 9'h010, 9'h010, 8'hA0, 8'hA0},
		'{8'h84, 8'hD1, 1'b1, 9'h020, 9'h021, 8'hB0, 8'hB1},
		'{8'h87, 8'hD6, 1'b0, 9'h106, 9'h000, 8'hC0, 8'hC2},
		'{8'h87, 8'hD3, 1'b1, 9'h0FE, 9'h000, 8'hD0, 8'hD2}};

	logic clk, rst, page_256, saw_full;
	logic cs_n, sck, si, so, so_oe, busy, wr_fifo_ready;
	int   miscompares, samples_checked;

	sfrb_sequencer #(.PAGES(PG), .EP_CYCLES(EP), .FIFO_DEPTH(WR_FIFO_DEPTH))
	i_dut (
		.clk(clk), .rst(rst), .cs_n(cs_n), .sck(sck), .si(si),
		.page_256(page_256), .so(so), .so_oe(so_oe), .busy(busy),
		.wr_fifo_ready(wr_fifo_ready)
	);
	sfrb_host_model i_host (
		.clk(clk), .so(so), .so_oe(so_oe), .cs_n(cs_n), .sck(sck), .si(si)
	);

	initial clk = 1'b0;
	always #2.5 clk = ~clk;

	// remember any refusal of the write fifo
	always @(posedge clk)
		if (wr_fifo_ready === 1'b0)
			saw_full <= 1'b1;

	task automatic check_value(input string what, input logic [15:0] seen,
		input logic [15:0] exp);
		samples_checked++;
		if (seen !== exp)
		begin
			miscompares++;
			$display("unexpected %s: expected %h seen %h", what, exp, seen);
		end
	endtask : check_value

	function automatic logic [23:0] baddr(input logic [8:0] off);
		return page_256 ? {16'hFFFF, off[7:0]} : {15'h7FFF, off};
	endfunction : baddr

	function automatic logic [23:0] maddr(input logic [10:0] p,
		input logic [8:0] b);
		return page_256 ? {5'h00, p, b[7:0]} : {4'h0, p, b};
	endfunction : maddr

	task automatic set_mode(input logic m);
		@(posedge clk) page_256 <= m;
		repeat (4) @(posedge clk);
	endtask : set_mode

	// opcode, three address bytes, dummies
	task automatic head(input logic [7:0] op, input logic [23:0] a,
		input int nd);
		logic [7:0] d;
		i_host.start_cmd();
		i_host.xfer(op, d);
		for (int k = 2; k >= 0; k--)
			i_host.xfer(a[8*k +: 8], d);
		for (int k = 0; k < nd; k++)
			i_host.xfer(8'hFF, d);
	endtask : head

	task automatic wr(input logic [7:0] v);
		logic [7:0] d;
		i_host.xfer(v, d);
	endtask : wr

	task automatic rd(input string what, input logic [7:0] exp);
		logic [7:0] d;
		i_host.xfer(8'h00, d);
		check_value(what, {8'h00, d}, {8'h00, exp});
	endtask : rd

	task automatic prog(input logic [7:0] op, input logic [10:0] p);
		int n;
		head(op, page_256 ? {5'h1F, p, 8'hFF} : {4'hF, p, 9'h1FF}, 0);
		i_host.stop_cmd();
		for (n = 0; n < 20 && busy !== 1'b1; n++)
			@(posedge clk);
		check_value("busy raised", {15'h0000, busy}, 16'h0001);
	endtask : prog

	task automatic wait_idle();
		int n;
		for (n = 0; n < EP + 100 && busy !== 1'b0; n++)
			@(posedge clk);
		check_value("busy cleared", {15'h0000, busy}, 16'h0000);
		repeat (60) @(posedge clk);
	endtask : wait_idle

	task automatic done(input string name);
		$display("test %s done", name);
	endtask : done

	task automatic complete_run();
		$display("checked %0d mismatched %0d", samples_checked, miscompares);
		if (miscompares == 0 && samples_checked > 0)
			$display("verification passed");
		else
			$display("verification failed");
		$finish;
	endtask : complete_run

	// watchdog sized well past the expected run
	initial
	begin
		repeat (80000) @(posedge clk);
		miscompares++;
		complete_run();
	end

	initial
	begin
		rst = 1'b1;
		page_256 = 1'b0;
		saw_full = 1'b0;
		miscompares = 0;
		samples_checked = 0;
		repeat (3) @(posedge clk);
		rst <= 1'b0;
		@(posedge clk);
		#1;
		check_value("oe at reset", {15'h0000, so_oe}, 16'h0000);
		check_value("busy at reset", {15'h0000, busy}, 16'h0000);
		check_value("ready at reset", {15'h0000, wr_fifo_ready}, 16'h0001);
		repeat (4) @(posedge clk);
		done("reset");
		// table of buffer write and read pairs
		foreach (rows[i])
		begin
			set_mode(rows[i].mode);
			head(rows[i].wop, baddr(rows[i].woff), 0);
			for (int k = 0; k < 4; k++)
				wr(rows[i].base + k[7:0]);
			i_host.stop_cmd();
			head(rows[i].rop, baddr(rows[i].roff), BUF_READ_DUMMY);
			rd("buffer byte", rows[i].exp0);
			rd("buffer next", rows[i].exp0 + 8'h01);
			i_host.stop_cmd();
			done("row");
		end
		// wrap at the end of a buffer
		set_mode(1'b0);
		head(8'h84, baddr(9'h107), 0);
		wr(8'h5A);
		wr(8'h6B);
		i_host.stop_cmd();
		head(8'hD4, baddr(9'h107), 1);
		rd("buf1 last", 8'h5A);
		rd("buf1 wrap", 8'h6B);
		i_host.stop_cmd();
		head(8'hD6, baddr(9'h107), 1);
		rd("buf2 last", 8'hC1);
		rd("buf2 wrap", 8'hD2);
		i_host.stop_cmd();
		check_value("oe after read", {15'h0000, so_oe}, 16'h0000);
		done("wrap");
		// unknown opcode keeps the output released
		head(8'h5C, 24'h000000, 1);
		check_value("ignored oe", {15'h0000, so_oe}, 16'h0000);
		i_host.stop_cmd();
		done("ignored");
		// programs with erase in standard mode
		prog(8'h83, 11'd5);
		wait_idle();
		prog(8'h86, 11'd6);
		wait_idle();
		prog(8'h83, 11'd7);
		wait_idle();
		done("program");
		// binary mode program with writes queued behind busy
		set_mode(1'b1);
		prog(8'h86, 11'd0);
		saw_full = 1'b0;
		head(8'h87, baddr(9'h040), 0);
		for (int k = 0; k < 18; k++)
			wr(8'hE0 + k[7:0]);
		i_host.stop_cmd();
		check_value("fifo refused", {15'h0000, saw_full}, 16'h0001);
		wait_idle();
		check_value("fifo drained", {15'h0000, wr_fifo_ready}, 16'h0001);
		head(8'hD3, baddr(9'h04E), 1);
		rd("queued 14", 8'hEE);
		rd("queued 15", 8'hEF);
		i_host.stop_cmd();
		done("fifo");
		// page and continuous reads in standard mode
		set_mode(1'b0);
		head(8'hD2, maddr(11'd5, 9'h010), PAGE_READ_DUMMY);
		rd("page byte", 8'hA0);
		rd("page next", 8'hA1);
		i_host.stop_cmd();
		head(8'hD2, maddr(11'd5, 9'h107), PAGE_READ_DUMMY);
		rd("page last", 8'h5A);
		rd("page wrap", 8'h6B);
		i_host.stop_cmd();
		head(8'h03, maddr(11'd5, 9'h107), 0);
		rd("array last", 8'h5A);
		rd("next page", 8'hD2);
		rd("next page 1", 8'hD3);
		i_host.stop_cmd();
		head(8'h03, maddr(11'd7, 9'h107), 0);
		rd("array end", 8'h5A);
		rd("array wrap", 8'hD2);
		i_host.stop_cmd();
		done("array");
		// binary addressing and untouched buffers
		set_mode(1'b1);
		head(8'h03, maddr(11'd5, 9'h010), 0);
		rd("binary byte", 8'hA0);
		rd("binary next", 8'hA1);
		i_host.stop_cmd();
		head(8'hD1, baddr(9'h010), 1);
		rd("buffer kept", 8'hA0);
		i_host.stop_cmd();
		done("binary");
		// reset in the middle of a program, buffers keep their data
		prog(8'h83, 11'd1);
		repeat (50) @(posedge clk);
		rst <= 1'b1;
		repeat (3) @(posedge clk);
		rst <= 1'b0;
		@(posedge clk);
		#1;
		check_value("busy after reset", {15'h0000, busy}, 16'h0000);
		check_value("oe after reset", {15'h0000, so_oe}, 16'h0000);
		repeat (4) @(posedge clk);
		head(8'hD1, baddr(9'h010), 1);
		rd("buffer after reset", 8'hA0);
		i_host.stop_cmd();
		done("reset again");
		complete_run();
	end
endmodule : sfrb_sequencer_test
